// File: hw/timer_clk_consts.svh
// offsets, field positions, reset values and divide counts of the timer block
`ifndef TIMER_CLK_CONSTS_SVH
`define TIMER_CLK_CONSTS_SVH

// register indices; byte address is four times the index
`define IDX_T0_LOW 8'h8a
`define IDX_T1_LOW 8'h8b
`define IDX_T0_HIGH 8'h8c
`define IDX_T1_HIGH 8'h8d
`define IDX_CLK_CTL 8'h8e
`define IDX_RUN_CTL 8'h8f

// clock control fields
`define CTL_PRESC_LSB 0
`define CTL_PRESC_MSB 1
`define CTL_T0_SEL 2
`define CTL_T1_SEL 3
`define CTL_WIDTH 4

// run control fields
`define RUN_T0 0
`define RUN_T1 1
`define RUN_T0_EXT 2
`define RUN_T1_EXT 3
`define RUN_WIDTH 4

`define RST_CTL 4'h0
`define RST_RUN 4'h0
`define RST_COUNT 16'h0000

// prescale codes and divisors
`define CODE_DIV_12 2'h0
`define CODE_DIV_4 2'h1
`define CODE_DIV_48 2'h2
`define DIV_12 6'h0c
`define DIV_4 6'h04
`define DIV_48 6'h30
`define EXT_DIV_LAST 3'h7

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// File: hw/timer_clk_pkg.sv
// types shared by the timer clock and count block
`default_nettype none
package timer_clk_pkg;

    typedef enum logic [2:0] {
        WR_IDLE = 3'h0,
        WR_AW = 3'h1,
        WR_EXEC = 3'h3,
        WR_RESP = 3'h2,
        WR_W = 3'h4
    } wr_state_type;

    typedef struct packed {
        wr_state_type wst;
        logic [7:0] widx;
        logic whit;
        logic [7:0] wdat;
        logic wen;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [3:0] ctl;
        logic [3:0] run;
        logic [1:0][15:0] cnt;
        logic [1:0] ovf;
    } top_state_type;

    typedef struct packed {
        logic [1:0] code;
        logic [5:0] cnt;
        logic tick;
        logic sync1;
        logic sync2;
        logic sync3;
        logic [2:0] ecnt;
        logic etick;
    } presc_state_type;

endpackage
`default_nettype wire

// File: hw/prescale_if.sv
// prescale code down, tick pulses up between the block and its prescaler
`timescale 1ns/10ps
`default_nettype none
interface prescale_if;
    logic [1:0] code;
    logic ext_level;
    logic presc_tick;
    logic ext_tick;
    modport ctl (
        output code,
        output ext_level,
        input presc_tick,
        input ext_tick
    );
    modport gen (
        input code,
        input ext_level,
        output presc_tick,
        output ext_tick
    );
endinterface
`default_nettype wire

// File: hw/tick_prescaler.sv
// shared prescaler and external clock divide-by-eight tick source
`timescale 1ns/10ps
`default_nettype none
`include "timer_clk_consts.svh"
module tick_prescaler (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    prescale_if.gen pif
);
    import timer_clk_pkg::*;

    presc_state_type q;
    presc_state_type d;
    logic [5:0] div;

    always_comb begin
        case (pif.code)
            `CODE_DIV_12: div = `DIV_12;
            `CODE_DIV_4: div = `DIV_4;
            `CODE_DIV_48: div = `DIV_48;
            default: div = `DIV_12;
        endcase
        d = q;
        d.tick = 1'b0;
        d.etick = 1'b0;
        d.code = pif.code;
        // a new code restarts the count so no short period leaks out
        if (pif.code != q.code) begin
            d.cnt = 6'h00;
        end else if (q.cnt >= div - 6'h01) begin
            d.cnt = 6'h00;
            d.tick = 1'b1;
        end else begin
            d.cnt = q.cnt + 6'h01;
        end
        d.sync1 = pif.ext_level;
        d.sync2 = q.sync1;
        d.sync3 = q.sync2;
        if (q.sync2 && !q.sync3) begin
            d.ecnt = q.ecnt + 3'h1;
            d.etick = (q.ecnt == `EXT_DIV_LAST);
        end
    end

    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign pif.presc_tick = q.tick;
    assign pif.ext_tick = q.etick;

    // cycles since the last tick or code change
    logic [5:0] gap_q;
    logic [2:0] edges_q;
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            gap_q <= 6'h00;
            edges_q <= 3'h0;
        end else begin
            if (pif.code != q.code) begin
                gap_q <= 6'h00;
            end else if (q.tick) begin
                gap_q <= 6'h01;
            end else begin
                gap_q <= gap_q + 6'h01;
            end
            if (q.sync2 && !q.sync3) begin
                edges_q <= edges_q + 3'h1;
            end
        end
    end

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);

    sequence s_div4_tick;
        (q.tick && pif.code == `CODE_DIV_4)
            ##1 (pif.code == `CODE_DIV_4)[*3];
    endsequence
    property p_div4;
        s_div4_tick |=> q.tick;
    endproperty
    a_div4: assert property (p_div4)
        else $error("divide by 4 period wrong");

    property p_gap;
        q.tick |-> (q.code == `CODE_DIV_12 && gap_q == `DIV_12)
            || (q.code == `CODE_DIV_4 && gap_q == `DIV_4)
            || (q.code == `CODE_DIV_48 && gap_q == `DIV_48)
            || (q.code == 2'h3);
    endproperty
    a_gap: assert property (p_gap)
        else $error("prescaled tick period wrong");

    property p_code3;
        (q.tick && q.code == 2'h3) |-> gap_q == `DIV_12;
    endproperty
    a_code3: assert property (p_code3)
        else $error("reserved code not dividing by 12");

    property p_ext8;
        (q.sync2 && !q.sync3) |=> (q.etick == (edges_q == 3'h0));
    endproperty
    a_ext8: assert property (p_ext8)
        else $error("external tick not every eighth edge");
endmodule
`default_nettype wire

// File: hw/timer_clock_prescale_counters.sv
// timer clock selection, shared prescaler and count registers on axi4-lite
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
`include "timer_clk_consts.svh"
module timer_clock_prescale_counters (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic awvalid_i,
    output var logic awready_o,
    input wire logic [11:0] awaddr_i,
    input wire logic wvalid_i,
    output var logic wready_o,
    input wire logic [31:0] wdata_i,
    input wire logic [3:0] wstrb_i,
    output var logic bvalid_o,
    input wire logic bready_i,
    output var logic [1:0] bresp_o,
    input wire logic arvalid_i,
    output var logic arready_o,
    input wire logic [11:0] araddr_i,
    output var logic rvalid_o,
    input wire logic rready_i,
    output var logic [31:0] rdata_o,
    output var logic [1:0] rresp_o,
    input wire logic ext_clk_i,
    output var logic t0_overflow_o,
    output var logic t1_overflow_o
);
    import timer_clk_pkg::*;

    top_state_type q;
    top_state_type d;
    logic [1:0] tick;
    logic [1:0] wr_t;

    prescale_if pif ();

    tick_prescaler u_presc (
        .sys_clk_i(sys_clk_i),
        .reset_i(reset_i),
        .pif(pif.gen)
    );

    assign pif.code = q.ctl[`CTL_PRESC_MSB:`CTL_PRESC_LSB];
    assign pif.ext_level = ext_clk_i;

    function automatic logic addr_hit(input logic [11:0] a);
        logic [7:0] i;
        i = a[9:2];
        addr_hit = (a[11:10] == 2'h0) && (i >= `IDX_T0_LOW)
            && (i <= `IDX_RUN_CTL);
    endfunction

    function automatic logic [7:0] rd_byte(input logic [7:0] i,
                                           input top_state_type s);
        case (i)
            `IDX_T0_LOW: rd_byte = s.cnt[0][7:0];
            `IDX_T0_HIGH: rd_byte = s.cnt[0][15:8];
            `IDX_T1_LOW: rd_byte = s.cnt[1][7:0];
            `IDX_T1_HIGH: rd_byte = s.cnt[1][15:8];
            `IDX_CLK_CTL: rd_byte = {4'h0, s.ctl};
            `IDX_RUN_CTL: rd_byte = {4'h0, s.run};
            default: rd_byte = 8'h00;
        endcase
    endfunction

    // a pending write lands in the exec state
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            wr_t[i] = (q.wst == WR_EXEC) && q.whit && q.wen
                && ((q.widx == `IDX_T0_LOW + 8'(i))
                || (q.widx == `IDX_T0_HIGH + 8'(i)));
        end
    end

    // per timer count clock: external, system or prescaled
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            if (q.run[`RUN_T0_EXT + i]) begin
                tick[i] = q.run[`RUN_T0 + i] && pif.ext_tick;
            end else if (q.ctl[`CTL_T0_SEL + i]) begin
                tick[i] = q.run[`RUN_T0 + i];
            end else begin
                tick[i] = q.run[`RUN_T0 + i] && pif.presc_tick;
            end
        end
    end

    always_comb begin
        d = q;
        // read channel
        if (q.rvalid && rready_i) begin
            d.rvalid = 1'b0;
        end
        if (arvalid_i && q.arready) begin
            d.rvalid = 1'b1;
            d.rdata = {24'h000000, rd_byte(araddr_i[9:2], q)};
            d.rresp = addr_hit(araddr_i) ? `RESP_OKAY : `RESP_SLVERR;
        end
        d.arready = !d.rvalid;
        // write channel, address and data in either order
        if (awvalid_i && q.awready) begin
            d.widx = awaddr_i[9:2];
            d.whit = addr_hit(awaddr_i);
        end
        if (wvalid_i && q.wready) begin
            d.wdat = wdata_i[7:0];
            d.wen = wstrb_i[0];
        end
        case (q.wst)
            WR_IDLE: begin
                // readies are low for one cycle after reset
                if (awvalid_i && q.awready && wvalid_i && q.wready) begin
                    d.wst = WR_EXEC;
                end else if (awvalid_i && q.awready) begin
                    d.wst = WR_AW;
                end else if (wvalid_i && q.wready) begin
                    d.wst = WR_W;
                end
            end
            WR_AW: begin
                if (wvalid_i) begin
                    d.wst = WR_EXEC;
                end
            end
            WR_W: begin
                if (awvalid_i) begin
                    d.wst = WR_EXEC;
                end
            end
            WR_EXEC: begin
                d.bvalid = 1'b1;
                d.bresp = q.whit ? `RESP_OKAY : `RESP_SLVERR;
                d.wst = WR_RESP;
            end
            WR_RESP: begin
                if (bready_i) begin
                    d.bvalid = 1'b0;
                    d.wst = WR_IDLE;
                end
            end
            default: d.wst = WR_IDLE;
        endcase
        d.awready = (d.wst == WR_IDLE) || (d.wst == WR_W);
        d.wready = (d.wst == WR_IDLE) || (d.wst == WR_AW);
        // counting; a software load of either byte wins that cycle
        for (int i = 0; i < 2; i++) begin
            d.ovf[i] = 1'b0;
            if (wr_t[i]) begin
                if (q.widx == `IDX_T0_LOW + 8'(i)) begin
                    d.cnt[i][7:0] = q.wdat;
                end else begin
                    d.cnt[i][15:8] = q.wdat;
                end
            end else if (tick[i]) begin
                d.cnt[i] = q.cnt[i] + 16'h0001;
                d.ovf[i] = (q.cnt[i] == 16'hffff);
            end
        end
        // control writes; run changes never touch the counts
        if ((q.wst == WR_EXEC) && q.whit && q.wen) begin
            if (q.widx == `IDX_CLK_CTL) begin
                d.ctl = q.wdat[`CTL_WIDTH-1:0];
            end
            if (q.widx == `IDX_RUN_CTL) begin
                d.run = q.wdat[`RUN_WIDTH-1:0];
            end
        end
    end

    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            q <= '0;
            q.wst <= WR_IDLE;
            q.ctl <= `RST_CTL;
            q.run <= `RST_RUN;
            q.cnt[0] <= `RST_COUNT;
            q.cnt[1] <= `RST_COUNT;
        end else begin
            q <= d;
        end
    end

    assign awready_o = q.awready;
    assign wready_o = q.wready;
    assign bvalid_o = q.bvalid;
    assign bresp_o = q.bresp;
    assign arready_o = q.arready;
    assign rvalid_o = q.rvalid;
    assign rdata_o = q.rdata;
    assign rresp_o = q.rresp;
    assign t0_overflow_o = q.ovf[0];
    assign t1_overflow_o = q.ovf[1];

    // checks
    logic [15:0] c0;
    logic [15:0] c1;
    logic [7:0] wd;
    assign c0 = q.cnt[0];
    assign c1 = q.cnt[1];
    assign wd = q.wdat;

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);

    sequence s_t1_on;
        q.run[`RUN_T1] && !q.run[`RUN_T1_EXT] && !wr_t[1];
    endsequence
    sequence s_t0_on;
        q.run[`RUN_T0] && !q.run[`RUN_T0_EXT] && !wr_t[0];
    endsequence

    property p_t1_sys;
        s_t1_on and q.ctl[`CTL_T1_SEL] |=> c1 == $past(c1) + 16'h0001;
    endproperty
    a_t1_sys: assert property (p_t1_sys)
        else $error("timer one missed a system clock count");

    property p_t1_pre;
        s_t1_on and !q.ctl[`CTL_T1_SEL] and !pif.presc_tick
            |=> $stable(c1);
    endproperty
    a_t1_pre: assert property (p_t1_pre)
        else $error("timer one counted without prescaled tick");

    property p_t0_sys;
        s_t0_on and q.ctl[`CTL_T0_SEL] |=> c0 == $past(c0) + 16'h0001;
    endproperty
    a_t0_sys: assert property (p_t0_sys)
        else $error("timer zero missed a system clock count");

    property p_t0_pre;
        s_t0_on and !q.ctl[`CTL_T0_SEL] and !pif.presc_tick
            |=> $stable(c0);
    endproperty
    a_t0_pre: assert property (p_t0_pre)
        else $error("timer zero counted without prescaled tick");

    property p_shared;
        s_t0_on and s_t1_on and !q.ctl[`CTL_T0_SEL]
            and !q.ctl[`CTL_T1_SEL] and pif.presc_tick
            |=> (c0 == $past(c0) + 16'h0001)
            && (c1 == $past(c1) + 16'h0001);
    endproperty
    a_shared: assert property (p_shared)
        else $error("prescaled tick not shared by both timers");

    property p_ext_hold;
        q.run[`RUN_T0] && q.run[`RUN_T0_EXT] && !wr_t[0]
            && !pif.ext_tick |=> $stable(c0);
    endproperty
    a_ext_hold: assert property (p_ext_hold)
        else $error("external count moved without a tick");

    sequence s_rd_ctl;
        arvalid_i && q.arready && addr_hit(araddr_i)
            && (araddr_i[9:2] == `IDX_CLK_CTL);
    endsequence
    property p_ctl_rd;
        s_rd_ctl |=> q.rvalid && (q.rdata[31:4] == 28'h0000000);
    endproperty
    a_ctl_rd: assert property (p_ctl_rd)
        else $error("upper control bits read non-zero");

    property p_t0_wr;
        wr_t[0] && (q.widx == `IDX_T0_LOW) |=> c0[7:0] == $past(wd);
    endproperty
    a_t0_wr: assert property (p_t0_wr)
        else $error("timer zero low byte write lost");

    property p_t1_wr;
        wr_t[1] && (q.widx == `IDX_T1_HIGH) |=> c1[15:8] == $past(wd);
    endproperty
    a_t1_wr: assert property (p_t1_wr)
        else $error("timer one high byte write lost");

    property p_t0_wrap;
        tick[0] && !wr_t[0] && (c0 == 16'hffff)
            |=> q.ovf[0] && (c0 == 16'h0000);
    endproperty
    a_t0_wrap: assert property (p_t0_wrap)
        else $error("timer zero wrap not flagged");

    property p_run_keep;
        (q.wst == WR_EXEC) && q.whit && q.wen && (q.widx == `IDX_RUN_CTL)
            && !q.run[`RUN_T0] |=> c0 == $past(c0);
    endproperty
    a_run_keep: assert property (p_run_keep)
        else $error("starting timer zero changed its count");

    property p_bresp;
        (q.wst == WR_EXEC) |=> q.bvalid ##0 (q.wst == WR_RESP);
    endproperty
    a_bresp: assert property (p_bresp)
        else $error("write response not raised after write");
endmodule
`default_nettype wire

// File: verif/timer_clock_prescale_counters_bench.sv
// self-checking bench for the timer clock and count block
`timescale 1ns/10ps
`default_nettype none
`include "timer_clk_consts.svh"
module timer_clock_prescale_counters_bench;
    logic sys_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic awvalid_i = 1'b0;
    logic wvalid_i = 1'b0;
    logic bready_i = 1'b0;
    logic arvalid_i = 1'b0;
    logic rready_i = 1'b0;
    logic ext_clk_i = 1'b0;
    logic [11:0] awaddr_i = 12'h000;
    logic [11:0] araddr_i = 12'h000;
    logic [31:0] wdata_i = 32'h0000_0000;
    logic [3:0] wstrb_i = 4'h0;
    logic awready_o, wready_o, bvalid_o, arready_o, rvalid_o;
    logic t0_overflow_o, t1_overflow_o;
    logic [1:0] bresp_o, rresp_o;
    logic [31:0] rdata_o;
    int n_mismatch = 0;
    int checks_done = 0;
    int seed = 46020;
    int cyc = 0;
    int acc = 0;
    int n_ovf0 = 0;
    int n_ovf1 = 0;
    logic [1:0] r;
    logic [31:0] v, v2;
    logic [7:0] model [4];

    timer_clock_prescale_counters i_dut (
        .sys_clk_i(sys_clk_i), .reset_i(reset_i),
        .awvalid_i(awvalid_i), .awready_o(awready_o), .awaddr_i(awaddr_i),
        .wvalid_i(wvalid_i), .wready_o(wready_o), .wdata_i(wdata_i),
        .wstrb_i(wstrb_i), .bvalid_o(bvalid_o), .bready_i(bready_i),
        .bresp_o(bresp_o), .arvalid_i(arvalid_i), .arready_o(arready_o),
        .araddr_i(araddr_i), .rvalid_o(rvalid_o), .rready_i(rready_i),
        .rdata_o(rdata_o), .rresp_o(rresp_o), .ext_clk_i(ext_clk_i),
        .t0_overflow_o(t0_overflow_o), .t1_overflow_o(t1_overflow_o)
    );

    initial begin
        forever #4 sys_clk_i = ~sys_clk_i;
    end

    always @(posedge sys_clk_i) begin
        cyc <= cyc + 1;
    end

    // wrap pulses stand one cycle; counted mid-cycle
    always @(negedge sys_clk_i) begin
        if (t0_overflow_o === 1'b1) n_ovf0 <= n_ovf0 + 1;
        if (t1_overflow_o === 1'b1) n_ovf1 <= n_ovf1 + 1;
    end

    task end_sim;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp,
             input string m);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    task hang(input int n);
        if (n >= 1000) begin
            n_mismatch++;
            $display("MISMATCH %0t bus handshake never came", $time);
        end
    endtask

    // write one word; address and data released as each is taken
    task wr(input logic [7:0] idx, input logic [31:0] d,
            input logic [3:0] s, output logic [1:0] resp);
        logic a, w, b;
        int n;
        b = 1'b0;
        n = 0;
        awvalid_i <= 1'b1;
        awaddr_i <= {2'h0, idx, 2'h0};
        wvalid_i <= 1'b1;
        wdata_i <= d;
        wstrb_i <= s;
        bready_i <= 1'b1;
        while (!b && n < 1000) begin
            @(negedge sys_clk_i);
            a = awvalid_i && awready_o;
            w = wvalid_i && wready_o;
            b = bvalid_o;
            resp = bresp_o;
            n++;
            @(posedge sys_clk_i);
            if (a) awvalid_i <= 1'b0;
            if (w) wvalid_i <= 1'b0;
        end
        bready_i <= 1'b0;
        hang(n);
        @(posedge sys_clk_i);
    endtask

    // read one word; acc holds the cycle of the address handshake
    task rd(input logic [7:0] idx, output logic [31:0] d,
            output logic [1:0] resp);
        logic a, b;
        int n;
        b = 1'b0;
        n = 0;
        arvalid_i <= 1'b1;
        araddr_i <= {2'h0, idx, 2'h0};
        rready_i <= 1'b1;
        while (!b && n < 1000) begin
            @(negedge sys_clk_i);
            a = arvalid_i && arready_o;
            if (a) acc = cyc;
            b = rvalid_o;
            d = rdata_o;
            resp = rresp_o;
            n++;
            @(posedge sys_clk_i);
            if (a) arvalid_i <= 1'b0;
        end
        rready_i <= 1'b0;
        hang(n);
        @(posedge sys_clk_i);
    endtask

    function automatic int div(input int code, input logic sel);
        if (sel) return 1;
        case (code)
            1: return 4;
            2: return 48;
            default: return 12;
        endcase
    endfunction

    // count delta over d cycles at one tick per p cycles, phase slack one
    function automatic logic near(input int got, input int d, input int p);
        int e;
        e = d / p;
        return ((got - e) & 255) <= 1 || ((e - got) & 255) <= 1;
    endfunction

    task meas(input logic [7:0] idx, input int p, input string m);
        logic [31:0] a, b;
        int t;
        rd(idx, a, r);
        t = acc;
        repeat (160) @(posedge sys_clk_i);
        rd(idx, b, r);
        chk(near((b[7:0] - a[7:0]) & 255, acc - t, p), 1'b1, m);
    endtask

    initial begin
        #400000;
        n_mismatch++;
        $display("MISMATCH %0t watchdog ran out", $time);
        end_sim;
    end

    initial begin
        logic s0;
        int idx;
        int o0;
        int o1;
        repeat (16) @(posedge sys_clk_i);
        reset_i <= 1'b0;
        @(posedge sys_clk_i);
        for (int i = 0; i < 6; i++) begin
            rd(8'h8a + i, v, r);
            chk(v, 32'h0, "reset value");
        end
        $display("test reset values done");
        wr(`IDX_RUN_CTL, 32'h5, 4'h1, r);
        rd(`IDX_T0_LOW, v, r);
        repeat (80) begin
            ext_clk_i <= 1'b1;
            repeat (3) @(posedge sys_clk_i);
            ext_clk_i <= 1'b0;
            repeat (3) @(posedge sys_clk_i);
        end
        repeat (8) @(posedge sys_clk_i);
        rd(`IDX_T0_LOW, v2, r);
        chk((v2 - v) & 32'hff, 32'ha, "ext ticks");
        wr(`IDX_RUN_CTL, 32'h0, 4'h1, r);
        $display("test external clock done");
        for (int i = 0; i < 4; i++) begin
            model[i] = 8'h00;
        end
        for (int i = 0; i < 12; i++) begin
            idx = $unsigned($random(seed)) % 4;
            v = $random(seed);
            wr(8'h8a + idx, v, 4'h1, r);
            chk(r, `RESP_OKAY, "write resp");
            model[idx] = v[7:0];
            wr(8'h8a + idx, ~v, 4'h0, r);
            rd(8'h8a + idx, v2, r);
            chk(v2, {24'h0, model[idx]}, "count byte");
        end
        wr(`IDX_CLK_CTL, 32'hff, 4'h1, r);
        rd(`IDX_CLK_CTL, v, r);
        chk(v, 32'h0f, "ctl upper bits");
        v2 = $random(seed);
        wr(`IDX_CLK_CTL, v2, 4'h1, r);
        rd(`IDX_CLK_CTL, v, r);
        chk(v, {28'h0, v2[3:0]}, "ctl random");
        wr(8'h90, 32'h1, 4'h1, r);
        chk(r, `RESP_SLVERR, "unmapped write");
        rd(8'h89, v, r);
        chk(v, 32'h0, "unmapped read data");
        chk(r, `RESP_SLVERR, "unmapped read");
        $display("test register access done");
        wr(`IDX_CLK_CTL, 32'h2, 4'h1, r);
        wr(`IDX_T0_LOW, 32'h40, 4'h1, r);
        wr(`IDX_RUN_CTL, 32'h1, 4'h1, r);
        rd(`IDX_T0_LOW, v, r);
        chk(v - 32'h40 < 3, 1'b1, "start keeps load");
        $display("test run start done");
        for (int c = 0; c < 4; c++) begin
            s0 = $random(seed);
            wr(`IDX_CLK_CTL, {s0 ^ 1'b1, s0, c[1:0]}, 4'h1, r);
            wr(`IDX_RUN_CTL, 32'h3, 4'h1, r);
            meas(`IDX_T0_LOW, div(c, s0), "t0 rate");
            meas(`IDX_T1_LOW, div(c, !s0), "t1 rate");
            wr(`IDX_CLK_CTL, {2'h0, c[1:0]}, 4'h1, r);
            meas(`IDX_T0_LOW, div(c, 0), "shared t0");
            meas(`IDX_T1_LOW, div(c, 0), "shared t1");
        end
        $display("test clock select and prescale done");
        wr(`IDX_RUN_CTL, 32'h0, 4'h1, r);
        wr(`IDX_CLK_CTL, 32'hc, 4'h1, r);
        for (int i = 0; i < 4; i++) begin
            wr(8'h8a + i, 32'hff, 4'h1, r);
        end
        o0 = n_ovf0;
        o1 = n_ovf1;
        wr(`IDX_RUN_CTL, 32'h3, 4'h1, r);
        repeat (4) @(posedge sys_clk_i);
        wr(`IDX_RUN_CTL, 32'h0, 4'h1, r);
        chk(n_ovf0 - o0, 1, "t0 wrap pulse");
        chk(n_ovf1 - o1, 1, "t1 wrap pulse");
        rd(`IDX_T0_HIGH, v, r);
        chk(v, 32'h0, "t0 high after wrap");
        rd(`IDX_T1_HIGH, v, r);
        chk(v, 32'h0, "t1 high after wrap");
        $display("test count wrap done");
        end_sim;
    end
endmodule
`default_nettype wire
